/* ellc_ctrl.sv */
// Top of the external line controller: register slave, pending logic and event pulses.
//
// Local design decision: the Avalon-MM register port.
`default_nettype none
`timescale 1ns/100ps
module ellc_ctrl #(
  parameter int LINES = ellc_pkg::NUM_LINES
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic [ellc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [ellc_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [ellc_pkg::DATA_W-1:0] avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic [LINES-1:0]            ext_line_in,
  input  wire logic [LINES-1:0]            interrupt_enable,
  output logic      [LINES-1:0]            line_irq,
  output logic      [LINES-1:0]            line_event,
  output logic                             irq
);
  import ellc_pkg::*;

  typedef struct packed {
    ellc_bus_t        bus;
    logic [31:0]      rdata;
    logic [LINES-1:0] event_enable;
    logic [LINES-1:0] rising_edge_select;
    logic [LINES-1:0] falling_edge_select;
    logic [LINES-1:0] software_trigger;
    logic [LINES-1:0] pending_flags;
    logic [LINES-1:0] event_pulse;
    logic [LINES-1:0] irq_status;
    logic [LINES-1:0] irq_mask;
  } ellc_ctrl_t;

  ellc_ctrl_t       st_reg;
  ellc_ctrl_t       st_next;
  logic [LINES-1:0] line_level;
  logic [LINES-1:0] rise_pulse;
  logic [LINES-1:0] fall_pulse;
  logic             req;
  logic             take;
  logic             wr_take;
  logic             rd_take;
  logic [31:0]      wmask;
  logic [31:0]      wbits;
  logic [LINES-1:0] wbits_l;
  logic [LINES-1:0] trig_rise;
  logic [LINES-1:0] trig_fall;
  logic [LINES-1:0] pend_rise;
  logic [LINES-1:0] pend_fall;
  logic [LINES-1:0] soft_new;
  logic [LINES-1:0] pend_clear;
  logic [LINES-1:0] pend_set;
  logic [LINES-1:0] status_clear;

  if (LINES < 1 || LINES > DATA_W) begin : g_lines_check
    $error("ellc_ctrl supports between 1 and 32 lines.");
  end

  ellc_sync #(
    .WIDTH (LINES)
  ) u_sync (
    .mclk      (mclk),
    .rstn      (rstn),
    .async_in  (ext_line_in),
    .level_out (line_level)
  );

  ellc_edge #(
    .WIDTH (LINES)
  ) u_edge (
    .mclk       (mclk),
    .rstn       (rstn),
    .level_in   (line_level),
    .rise_pulse (rise_pulse),
    .fall_pulse (fall_pulse)
  );

  function automatic logic [31:0] zext(input logic [LINES-1:0] v);
    logic [31:0] r;
    r = '0;
    r[LINES-1:0] = v;
    return r;
  endfunction : zext

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic [31:0] read_word(input ellc_ctrl_t s, input logic [4:0] a);
    logic [31:0] r;
    r = UNMAPPED_READ;
    case (a)
      OFF_EVENT_ENABLE: begin
        r = zext(s.event_enable);
      end
      OFF_RISING_SELECT: begin
        r = zext(s.rising_edge_select);
      end
      OFF_FALLING_SELECT: begin
        r = zext(s.falling_edge_select);
      end
      OFF_SOFTWARE_TRIGGER: begin
        r = zext(s.software_trigger);
      end
      OFF_PENDING_FLAGS: begin
        r = zext(s.pending_flags);
      end
      OFF_IRQ_STATUS: begin
        r = zext(s.irq_status);
      end
      OFF_IRQ_MASK: begin
        r = zext(s.irq_mask);
      end
      default: begin
        r = UNMAPPED_READ;
      end
    endcase
    return r;
  endfunction : read_word

  // One wait cycle per access keeps read data registered and stable at the accepting edge.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & (st_reg.bus == ELLC_BUS_IDLE);
  assign take            = req & (st_reg.bus == ELLC_BUS_ACK);
  assign wr_take         = take & avs_write;
  assign rd_take         = take & avs_read;
  assign wmask           = lane_mask(avs_byteenable);
  assign wbits           = avs_writedata & wmask;
  assign wbits_l         = wbits[LINES-1:0];

  always_comb begin
    st_next = st_reg;

    unique case (st_reg.bus)
      ELLC_BUS_IDLE: begin
        if (req) begin
          st_next.bus   = ELLC_BUS_ACK;
          st_next.rdata = avs_read ? read_word(st_reg, avs_address) : UNMAPPED_READ;
        end
      end
      ELLC_BUS_ACK: begin
        st_next.bus   = ELLC_BUS_IDLE;
        st_next.rdata = UNMAPPED_READ;
      end
    endcase

    trig_rise = rise_pulse & st_reg.rising_edge_select;
    trig_fall = fall_pulse & st_reg.falling_edge_select;

    // An edge landing on a write to its own select register is dropped for pending and interrupt status, not for the event pulse.
    pend_rise = (wr_take && avs_address == OFF_RISING_SELECT) ? '0 : trig_rise;
    pend_fall = (wr_take && avs_address == OFF_FALLING_SELECT) ? '0 : trig_fall;

    soft_new   = '0;
    pend_clear = '0;
    if (wr_take) begin
      unique case (avs_address)
        OFF_EVENT_ENABLE: begin
          st_next.event_enable = wbits_l | (st_reg.event_enable & ~wmask[LINES-1:0]);
        end
        OFF_RISING_SELECT: begin
          st_next.rising_edge_select = wbits_l
                                     | (st_reg.rising_edge_select & ~wmask[LINES-1:0]);
        end
        OFF_FALLING_SELECT: begin
          st_next.falling_edge_select = wbits_l
                                      | (st_reg.falling_edge_select & ~wmask[LINES-1:0]);
        end
        OFF_SOFTWARE_TRIGGER: begin
          soft_new = wbits_l & ~st_reg.software_trigger;
        end
        OFF_PENDING_FLAGS: begin
          pend_clear = wbits_l;
        end
        OFF_IRQ_MASK: begin
          st_next.irq_mask = wbits_l | (st_reg.irq_mask & ~wmask[LINES-1:0]);
        end
        default: begin
          pend_clear = '0;
        end
      endcase
    end

    // Pending is set only for interrupt-enabled lines, so event-only lines never set it.
    pend_set = ((pend_rise | pend_fall) | soft_new) & interrupt_enable;

    st_next.pending_flags    = (st_reg.pending_flags & ~pend_clear) | pend_set;
    st_next.software_trigger = (st_reg.software_trigger & ~pend_clear) | soft_new;

    st_next.event_pulse = (trig_rise | trig_fall | soft_new) & st_reg.event_enable;

    // Only bits the reader actually saw are cleared, and a new set wins over the clear.
    status_clear       = rd_take && avs_address == OFF_IRQ_STATUS ? st_reg.rdata[LINES-1:0]
                                                                  : '0;
    st_next.irq_status = (st_reg.irq_status & ~status_clear) | pend_set;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg                     <= '0;
      st_reg.bus                 <= ELLC_BUS_IDLE;
      st_reg.rdata               <= UNMAPPED_READ;
      st_reg.event_enable        <= REG_RESET[LINES-1:0];
      st_reg.rising_edge_select  <= REG_RESET[LINES-1:0];
      st_reg.falling_edge_select <= REG_RESET[LINES-1:0];
      st_reg.software_trigger    <= REG_RESET[LINES-1:0];
      st_reg.pending_flags       <= PENDING_RESET[LINES-1:0];
      st_reg.event_pulse         <= '0;
      st_reg.irq_status          <= '0;
      st_reg.irq_mask            <= IRQ_MASK_RESET[LINES-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.rdata;
  assign line_irq     = st_reg.pending_flags & interrupt_enable;
  assign line_event   = st_reg.event_pulse;
  assign irq          = |(st_reg.irq_status & st_reg.irq_mask);
endmodule : ellc_ctrl
`default_nettype wire

/* ellc_pkg.sv */
// Constants shared by the external line edge and event controller.
// Function
// - Event request passes only with event enable set
// - Rising select makes rising edges trigger both paths
// - Falling select makes falling edges trigger both paths
// - Both selects set trigger on every edge
// - Rising edge during rising-select write sets no pending
// - Falling edge during falling-select write sets no pending
// - Software trigger write of one sets pending
// - Software trigger bit clears with its pending flag
// - Selected edge sets the line pending flag
// - Writing one clears pending, zero leaves it
// - Enable, select and trigger registers reset to zero
// - Pending reset value need not be defined
// - Interrupt enable gates each line interrupt request
// - Event pulse emitted without setting pending flag
`default_nettype none
package ellc_pkg;
  localparam int          NUM_LINES            = 18;
  localparam int          ADDR_W               = 5;
  localparam int          DATA_W               = 32;
  localparam logic [4:0]  OFF_EVENT_ENABLE     = 5'h04;
  localparam logic [4:0]  OFF_RISING_SELECT    = 5'h08;
  localparam logic [4:0]  OFF_FALLING_SELECT   = 5'h0c;
  localparam logic [4:0]  OFF_SOFTWARE_TRIGGER = 5'h10;
  localparam logic [4:0]  OFF_PENDING_FLAGS    = 5'h14;
  localparam logic [4:0]  OFF_IRQ_STATUS       = 5'h18;
  localparam logic [4:0]  OFF_IRQ_MASK         = 5'h1c;
  localparam logic [31:0] REG_RESET            = 32'h0000_0000;
  localparam logic [31:0] PENDING_RESET        = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RESET       = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ        = 32'h0000_0000;

  typedef enum logic [0:0] {
    ELLC_BUS_IDLE = 1'b0,
    ELLC_BUS_ACK  = 1'b1
  } ellc_bus_t;
endpackage : ellc_pkg
`default_nettype wire

/* ellc_sync.sv */
// Three-stage synchroniser that accepts a new level once stages two and three agree.
`default_nettype none
`timescale 1ns/100ps
module ellc_sync #(
  parameter int WIDTH = 18
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);
  import ellc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } ellc_sync_t;

  ellc_sync_t sync_reg;
  ellc_sync_t sync_next;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1) begin : g_width_check
    $error("ellc_sync needs at least one line.");
  end

  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = async_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    // A one-cycle blip never has stages two and three agree, so it never reaches the level.
    agree = ~(sync_reg.s2 ^ sync_reg.s3);
    sync_next.level = (sync_reg.s3 & agree) | (sync_reg.level & ~agree);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level_out = sync_reg.level;
endmodule : ellc_sync
`default_nettype wire

/* ellc_edge.sv */
// Edge detector giving one-cycle rising and falling pulses per line.
`default_nettype none
`timescale 1ns/100ps
module ellc_edge #(
  parameter int WIDTH = 18
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_pulse,
  output logic      [WIDTH-1:0] fall_pulse
);
  import ellc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } ellc_edge_t;

  ellc_edge_t edge_reg;
  ellc_edge_t edge_next;

  if (WIDTH < 1) begin : g_width_check
    $error("ellc_edge needs at least one line.");
  end

  always_comb begin
    edge_next = edge_reg;
    edge_next.prev = level_in;
    edge_next.rise = level_in & ~edge_reg.prev;
    edge_next.fall = ~level_in & edge_reg.prev;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= edge_next;
    end
  end

  assign rise_pulse = edge_reg.rise;
  assign fall_pulse = edge_reg.fall;
endmodule : ellc_edge
`default_nettype wire

/* ellc_chk.sv */
// Port assertions for the external line controller.
`timescale 1ns/100ps
`default_nettype none
module ellc_chk
  import ellc_pkg::*;
#(
  parameter int LINES = 18
) (
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [LINES-1:0]  ext_line_in,
  input wire logic [LINES-1:0]  interrupt_enable,
  input wire logic [LINES-1:0]  line_irq,
  input wire logic [LINES-1:0]  line_event,
  input wire logic              irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire             wr_ack  = avs_write && !avs_waitrequest && avs_byteenable == 4'hf;
  wire [LINES-1:0] wd      = avs_writedata[LINES-1:0];
  wire [LINES-1:0] sw_want = wd & interrupt_enable;
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_high;
    avs_readdata[DATA_W-1:LINES] == '0;
  endproperty
  a_high: assert property (p_high) else $error("unused read bits set");
  property p_gate;
    (line_irq & ~interrupt_enable) == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("request on disabled line");
  property p_pulse;
    (line_event & $past(line_event)) == '0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
  property p_quiet;
    ($stable(ext_line_in) && !avs_write)[*6] |=> line_event == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("event without cause");
  property p_clear;
    wr_ack && avs_address == OFF_PENDING_FLAGS |=> (line_irq & $past(wd)) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");
  property p_soft;
    wr_ack && avs_address == OFF_SOFTWARE_TRIGGER |=> (line_irq & $past(sw_want)) == $past(sw_want);
  endproperty
  a_soft: assert property (p_soft) else $error("soft trigger gave no request");
  property p_rst;
    $rose(rstn) |-> line_irq == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("request after reset");
endmodule : ellc_chk
bind ellc_ctrl ellc_chk #(.LINES(LINES)) ellc_chk_inst (.*);
`default_nettype wire

/* ellc_line_src.sv */
// Model of the sources that drive the external lines.
`timescale 1ns/100ps
`default_nettype none
module ellc_line_src (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [17:0] flip,
  output logic      [17:0] lines
);
  logic [2:0] hold_reg;
  // Each level is held for several clocks, so no glitch reaches the controller.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lines    <= 18'h0;
      hold_reg <= 3'h0;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end else if (flip != 18'h0) begin
      lines    <= lines ^ flip;
      hold_reg <= 3'h4;
    end
  end
endmodule : ellc_line_src
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the external line controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ellc_pkg::*;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [17:0] flip = 18'h0;
  logic [17:0] interrupt_enable = 18'h3ffff;
  logic [17:0] ev_seen = 18'h0;
  logic [17:0] ext_line_in;
  logic [17:0] line_irq;
  logic [17:0] line_event;
  logic [32:0] exp_q[$];
  logic [4:0]  offs[6] = '{OFF_EVENT_ENABLE, OFF_RISING_SELECT, OFF_FALLING_SELECT,
                           OFF_SOFTWARE_TRIGGER, OFF_PENDING_FLAGS, 5'h00};
  int          num_errors = 0;
  int          total_checks = 0;
  int          seed = 32'hba62;

  always #12.5 mclk = ~mclk;

  ellc_ctrl #(.LINES(18)) ellc_ctrl_inst (
    .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_line_in(ext_line_in), .interrupt_enable(interrupt_enable),
    .line_irq(line_irq), .line_event(line_event), .irq(irq));

  ellc_line_src ellc_line_src_inst (.mclk(mclk), .rstn(rstn), .flip(flip), .lines(ext_line_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // The master waits for the slave as long as it takes; only the watchdog ends a hang.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic skip = 1'b0);
    exp_q.push_back({skip, e});
    bus(1'b0, a, 32'h0);
  endtask : rd

  // Lines are toggled through the source model, then the bench waits n clocks.
  task automatic pulse(input logic [17:0] m, input int n);
    flip <= m;
    @(posedge mclk);
    flip <= 18'h0;
    repeat (n) @(posedge mclk);
  endtask : pulse

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge mclk) begin
    ev_seen <= ev_seen | line_event;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      if (exp_q[0][32] !== 1'b1) chk(avs_readdata, exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end

  // The whole sequence needs well under a thousand clocks.
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] v;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      v = $random(seed) & 32'h3ffff;
      wr(offs[i], v);
      rd(offs[i], v);
    end
    $display("test registers done");
    wr(OFF_EVENT_ENABLE, 32'h1);
    wr(OFF_RISING_SELECT, 32'h5);
    wr(OFF_FALLING_SELECT, 32'h6);
    interrupt_enable <= 18'h3fffe;
    pulse(18'h5, 10);
    chk({14'h0, ev_seen}, 32'h1);
    chk({14'h0, line_irq}, 32'h4);
    rd(OFF_PENDING_FLAGS, 32'h4);
    wr(OFF_PENDING_FLAGS, 32'h3ffff);
    interrupt_enable <= 18'h3ffff;
    $display("test events done");
    pulse(18'h7, 10);
    rd(OFF_PENDING_FLAGS, 32'h4);
    wr(OFF_PENDING_FLAGS, 32'h0);
    rd(OFF_PENDING_FLAGS, 32'h4);
    wr(OFF_PENDING_FLAGS, 32'h4);
    pulse(18'h7, 10);
    rd(OFF_PENDING_FLAGS, 32'h7);
    wr(OFF_PENDING_FLAGS, 32'h5);
    rd(OFF_PENDING_FLAGS, 32'h2);
    wr(OFF_PENDING_FLAGS, 32'h3ffff);
    $display("test edges done");
    wr(OFF_SOFTWARE_TRIGGER, 32'h8);
    rd(OFF_SOFTWARE_TRIGGER, 32'h8);
    rd(OFF_PENDING_FLAGS, 32'h8);
    wr(OFF_PENDING_FLAGS, 32'h8);
    rd(OFF_SOFTWARE_TRIGGER, 32'h0);
    $display("test software done");
    // The write starts four clocks after the flip and is accepted on the edge that sees the edge pulse.
    wr(OFF_RISING_SELECT, 32'h8);
    pulse(18'h8, 4);
    wr(OFF_RISING_SELECT, 32'h8);
    repeat (8) @(posedge mclk);
    rd(OFF_PENDING_FLAGS, 32'h0);
    wr(OFF_FALLING_SELECT, 32'h8);
    pulse(18'h8, 4);
    wr(OFF_FALLING_SELECT, 32'h8);
    repeat (8) @(posedge mclk);
    rd(OFF_PENDING_FLAGS, 32'h0);
    $display("test write collision done");
    rd(OFF_IRQ_STATUS, 32'h0, 1'b1);
    wr(OFF_IRQ_MASK, 32'h8);
    wr(OFF_SOFTWARE_TRIGGER, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h8);
    rd(OFF_IRQ_STATUS, 32'h8);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
